// [verilog/lcm_map.svh]
// Constants for the light curtain muting supervisor: register map, fields, resets, timing.
// Assumes a 125 MHz pclk and a one millisecond controller scan tick.
`ifndef LCM_MAP_SVH
`define LCM_MAP_SVH

// ==========================================================================
// Register offsets
`define LCM_OFS_CTRL 12'h000
`define LCM_OFS_SYNC 12'h004
`define LCM_OFS_MUTE 12'h008
`define LCM_OFS_DISC 12'h00c
`define LCM_OFS_STAT 12'h010

// ==========================================================================
// Control fields
`define LCM_CTRL_RUN 0
`define LCM_CTRL_FWD4 1
`define LCM_CTRL_OVR_DUAL 2

// ==========================================================================
// Reset values
`define LCM_CTRL_RST 3'h0
`define LCM_SYNC_RST 16'h0bb8
`define LCM_MUTE_RST 8'h78
`define LCM_DISC_RST 8'h1e

// ==========================================================================
// Timing
`define LCM_CLK_MHZ 125
`define LCM_SCAN_US 1000
`define LCM_SCAN_CYCLES (`LCM_SCAN_US * `LCM_CLK_MHZ)
`define LCM_MUTE_STEP_MS 17'h001f4

`endif

// [verilog/lcm_pkg.sv]
// Types shared by the light curtain muting supervisor.
// Assumes lcm_map.svh supplies all numeric constants.
package lcm_pkg;

	// ======================================================================
	// Supervisor states
	typedef enum logic [1:0] {
		LCM_WAIT_OFF,
		LCM_ARMED,
		LCM_FIRST,
		LCM_MUTING
	} lcm_state_e;

	// ======================================================================
	// Field inputs as one carrier
	typedef struct packed {
		logic curtain_a;
		logic curtain_b;
		logic override_a;
		logic override_b;
		logic first_entry_sensor;
		logic second_entry_sensor;
		logic first_exit_sensor;
		logic second_exit_sensor;
	} lcm_inputs_s;

	// ======================================================================
	// Status flags as one carrier
	typedef struct packed {
		logic output_enable;
		logic muting;
		logic fault;
		logic curtain_err;
		logic override_err;
		logic sync_err;
		logic seq_err;
	} lcm_flags_s;

endpackage

// [verilog/lcm_sync.sv]
// Two flip-flop synchroniser for the eight field inputs.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/10ps
module lcm_sync
	import lcm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] din,
	output logic [7:0] dout
);

	// ======================================================================
	// One two-stage chain per bit
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			logic meta;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta <= 1'b0;
					dout[i] <= 1'b0;
				end else begin
					meta <= din[i];
					dout[i] <= meta;
				end
			end
		end
	endgenerate

endmodule

// [verilog/lcm_pair_check.sv]
// Dual-channel input pair monitor with discrepancy timing and latched error.
// Assumes eval pulses once per scan after the pair sample has been refreshed.
`timescale 1ns/10ps
module lcm_pair_check
	import lcm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic eval,
	input wire logic a,
	input wire logic b,
	input wire logic run_start,
	input wire logic [7:0] disc_lim,
	output logic err
);

	logic [7:0] disc_cnt;
	logic seen_off;

	// ======================================================================
	// Discrepancy timer; a zero limit disables the check.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disc_cnt <= 8'h00;
		end else if (eval) begin
			if (a == b) begin
				disc_cnt <= 8'h00;
			end else if (disc_cnt != 8'hff) begin
				disc_cnt <= disc_cnt + 8'h01;
			end
		end
	end

	// ======================================================================
	// Error latch; a new mismatch wins over any clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err <= 1'b0;
			seen_off <= 1'b0;
		end else if (eval && a != b && disc_lim != 8'h00 && disc_cnt >= disc_lim) begin
			err <= 1'b1;
			seen_off <= 1'b0;
		end else if (run_start) begin
			err <= 1'b0;
			seen_off <= 1'b0;
		end else if (eval && err) begin
			if (!a && !b) begin
				seen_off <= 1'b1;
			end else if (a && b && seen_off) begin
				err <= 1'b0;
				seen_off <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Checks
	property p_err_hold;
		@(posedge pclk) disable iff (!presetn)
		err && !run_start && !eval |=> err;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error dropped");

endmodule

// [verilog/lcm_top.sv]
// Light curtain muting supervisor with APB register access.
// Assumes field inputs are asynchronous pins and the APB master follows the usual protocol.
//
// Contract
// - Curtain pair mismatch drops enable, sets fault and error; cleared by recovery or restart.
// - Override pair mismatch sets its error; cleared by pair recovery or restart.
// - Synchronisation error stays set until the next valid muting entry.
// - Sequence error stays set until idle-to-run restart.
// - Pending sync or sequence error with curtain blocked drops enable, sets fault; enable stays on while muting with a sequence error pending.
// - Muting starts only while the curtain pair is clear.
// - No muting start while any pair mismatch error is present.
// - Both entry sensors must be seen off before a start sequence.
// - Parallel mode mutes when first entry sensor, then second, turn on.
// - Start delay beyond the sync window raises the synchronisation error.
// - Start sensors in the wrong order raise the sequence error.
// - Curtain blocked before muting is reached drops enable.
// - Either entry sensor turning off ends muting; the code does so in parallel mode only.
// - Muting ends when the maximum muting time elapses.
// - Curtain blocked after muting ended drops enable.
// - Curtain pair mismatch ends muting and drops enable together.
// - Dual override mismatch ends muting and drops enable.
// - Muting is entered again whenever start conditions hold again.
// - While muting, enable stays on with the curtain blocked.
// - Forward four-sensor mode mutes on entry order, ends when first exit clears.
// - Sync window defaults to three seconds.
// - Muting limit in half-second steps up to 127.5 s; zero means unlimited.
// - Sequence checking starts only after all used sensors are seen off.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
`include "lcm_map.svh"
module lcm_top
	import lcm_pkg::*;
#(
	parameter int SCAN_CYCLES = `LCM_SCAN_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic curtain_a,
	input wire logic curtain_b,
	input wire logic override_a,
	input wire logic override_b,
	input wire logic first_entry_sensor,
	input wire logic second_entry_sensor,
	input wire logic first_exit_sensor,
	input wire logic second_exit_sensor,
	output logic output_enable,
	output logic muting_status,
	output logic fault_present,
	output logic curtain_pair_mismatch_error,
	output logic override_mismatch_error,
	output logic sync_error,
	output logic sequence_error
);

	lcm_inputs_s pins_s, snap;
	lcm_state_e state, next_state;
	logic [2:0] ctrl;
	logic [15:0] sync_lim, sync_cnt;
	logic [7:0] mute_lim, disc_lim;
	logic [31:0] scan_cnt, rd_val;
	logic [16:0] mute_cnt, mute_ticks;
	logic tick, eval, run_q, run_start, curtain_act, ovr_bad, start_mute, end_mute;
	logic set_sync, set_seq, exit_seen, wr_en, rd_ok;
	lcm_flags_s flags;

	assign run_start = ctrl[`LCM_CTRL_RUN] && !run_q;
	assign curtain_act = snap.curtain_a && snap.curtain_b;
	assign ovr_bad = ctrl[`LCM_CTRL_OVR_DUAL] && override_mismatch_error;
	assign mute_ticks = 17'(mute_lim) * `LCM_MUTE_STEP_MS;
	assign wr_en = psel && penable && pready && pwrite;

	// ======================================================================
	// Input synchronisers and pair monitors
	lcm_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({curtain_a, curtain_b, override_a, override_b, first_entry_sensor,
			second_entry_sensor, first_exit_sensor, second_exit_sensor}),
		.dout(pins_s)
	);

	lcm_pair_check u_curtain (
		.pclk(pclk),
		.presetn(presetn),
		.eval(eval),
		.a(snap.curtain_a),
		.b(snap.curtain_b),
		.run_start(run_start),
		.disc_lim(disc_lim),
		.err(curtain_pair_mismatch_error)
	);

	lcm_pair_check u_override (
		.pclk(pclk),
		.presetn(presetn),
		.eval(eval),
		.a(snap.override_a),
		.b(snap.override_b),
		.run_start(run_start),
		.disc_lim(disc_lim),
		.err(override_mismatch_error)
	);

	// ======================================================================
	// Scan tick; the snapshot is taken on tick and evaluated one clock later.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_cnt <= 32'h0;
			tick <= 1'b0;
			eval <= 1'b0;
			snap <= '0;
		end else begin
			tick <= (scan_cnt == 32'(SCAN_CYCLES - 1));
			scan_cnt <= (scan_cnt == 32'(SCAN_CYCLES - 1)) ? 32'h0 : scan_cnt + 32'h1;
			eval <= tick;
			if (tick) begin
				snap <= pins_s;
			end
		end
	end

	// ======================================================================
	// APB slave; one access cycle, unmapped addresses answer with pslverr.
	always_comb begin
		rd_val = 32'h0;
		rd_ok = 1'b1;
		unique case (paddr)
			`LCM_OFS_CTRL: rd_val = {29'h0, ctrl};
			`LCM_OFS_SYNC: rd_val = {16'h0, sync_lim};
			`LCM_OFS_MUTE: rd_val = {24'h0, mute_lim};
			`LCM_OFS_DISC: rd_val = {24'h0, disc_lim};
			`LCM_OFS_STAT: rd_val = {23'h0, state, flags};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !rd_ok;
			prdata <= (psel && !penable && !pwrite) ? rd_val : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `LCM_CTRL_RST;
			sync_lim <= `LCM_SYNC_RST;
			mute_lim <= `LCM_MUTE_RST;
			disc_lim <= `LCM_DISC_RST;
		end else if (wr_en) begin
			unique case (paddr)
				`LCM_OFS_CTRL: ctrl <= pwdata[2:0];
				`LCM_OFS_SYNC: sync_lim <= pwdata[15:0];
				`LCM_OFS_MUTE: mute_lim <= pwdata[7:0];
				`LCM_OFS_DISC: disc_lim <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
		end else begin
			run_q <= ctrl[`LCM_CTRL_RUN];
		end
	end

	// ======================================================================
	// Muting sequencer; transitions only on eval, except run off and, while muting, a curtain pair error or a dual-mode override error act at once.
	always_comb begin
		next_state = state;
		start_mute = 1'b0;
		end_mute = 1'b0;
		set_sync = 1'b0;
		set_seq = 1'b0;
		if (!ctrl[`LCM_CTRL_RUN]) begin
			next_state = LCM_WAIT_OFF;
		end else if (state == LCM_MUTING && (curtain_pair_mismatch_error || ovr_bad)) begin
			next_state = LCM_WAIT_OFF;
			end_mute = 1'b1;
		end else if (eval) begin
			unique case (state)
				LCM_WAIT_OFF: begin
					if (!snap.first_entry_sensor && !snap.second_entry_sensor &&
						(!ctrl[`LCM_CTRL_FWD4] ||
						(!snap.first_exit_sensor && !snap.second_exit_sensor))) begin
						next_state = LCM_ARMED;
					end
				end
				LCM_ARMED: begin
					if (snap.second_entry_sensor || (ctrl[`LCM_CTRL_FWD4] &&
						(snap.first_exit_sensor || snap.second_exit_sensor))) begin
						set_seq = 1'b1;
						next_state = LCM_WAIT_OFF;
					end else if (snap.first_entry_sensor) begin
						next_state = LCM_FIRST;
					end
				end
				LCM_FIRST: begin
					if (sync_cnt >= sync_lim) begin
						set_sync = 1'b1;
						next_state = LCM_WAIT_OFF;
					end else if (!snap.first_entry_sensor) begin
						next_state = LCM_WAIT_OFF;
					end else if (snap.second_entry_sensor) begin
						if (curtain_act && !curtain_pair_mismatch_error &&
							!override_mismatch_error) begin
							next_state = LCM_MUTING;
							start_mute = 1'b1;
						end else begin
							next_state = LCM_WAIT_OFF;
						end
					end
				end
				LCM_MUTING: begin
					if (mute_lim != 8'h00 && mute_cnt >= mute_ticks) begin
						end_mute = 1'b1;
					end else if (!ctrl[`LCM_CTRL_FWD4] &&
						(!snap.first_entry_sensor || !snap.second_entry_sensor)) begin
						end_mute = 1'b1;
					end else if (ctrl[`LCM_CTRL_FWD4] && exit_seen &&
						!snap.first_exit_sensor) begin
						end_mute = 1'b1;
					end
					if (end_mute) begin
						next_state = LCM_WAIT_OFF;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= LCM_WAIT_OFF;
		end else begin
			state <= next_state;
		end
	end

	// ======================================================================
	// Scan-rate timers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_cnt <= 16'h0;
			mute_cnt <= 17'h0;
			exit_seen <= 1'b0;
		end else if (eval) begin
			sync_cnt <= (state == LCM_FIRST && sync_cnt != 16'hffff) ? sync_cnt + 16'h1 : 16'h0;
			mute_cnt <= (state == LCM_MUTING && mute_cnt != 17'h1ffff) ?
				mute_cnt + 17'h1 : 17'h0;
			exit_seen <= (state == LCM_MUTING) && (exit_seen || snap.first_exit_sensor);
		end
	end

	// ======================================================================
	// Error flags; a new error wins over a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_error <= 1'b0;
		end else if (set_sync) begin
			sync_error <= 1'b1;
		end else if (start_mute) begin
			sync_error <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sequence_error <= 1'b0;
		end else if (set_seq) begin
			sequence_error <= 1'b1;
		end else if (run_start) begin
			sequence_error <= 1'b0;
		end
	end

	// ======================================================================
	// Outputs; enable follows the curtain unless muting holds it on.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_enable <= 1'b0;
			muting_status <= 1'b0;
			fault_present <= 1'b0;
		end else begin
			muting_status <= (next_state == LCM_MUTING);
			output_enable <= ctrl[`LCM_CTRL_RUN] && !curtain_pair_mismatch_error && !ovr_bad &&
				(muting_status || curtain_act);
			fault_present <= curtain_pair_mismatch_error || override_mismatch_error ||
				((sync_error || sequence_error) && !curtain_act);
		end
	end

	assign flags = '{output_enable, muting_status, fault_present, curtain_pair_mismatch_error,
		override_mismatch_error, sync_error, sequence_error};

	// ======================================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_cur_drop;
		$rose(curtain_pair_mismatch_error) |=> !output_enable && fault_present;
	endproperty
	a_cur_drop: assert property (p_cur_drop) else $error("mismatch kept enable");
	property p_sync_clr;
		$fell(sync_error) |-> muting_status;
	endproperty
	a_sync_clr: assert property (p_sync_clr) else $error("sync cleared early");
	property p_seq_clr;
		$fell(sequence_error) |-> $past(run_start);
	endproperty
	a_seq_clr: assert property (p_seq_clr) else $error("sequence cleared early");
	property p_err_fault;
		(sync_error || sequence_error) && !curtain_act |=> fault_present;
	endproperty
	a_err_fault: assert property (p_err_fault) else $error("fault missing");
	property p_start_ok;
		$rose(muting_status) |-> $past(curtain_act) && !$past(curtain_pair_mismatch_error) &&
			!$past(override_mismatch_error) && $past(state) == LCM_FIRST;
	endproperty
	a_start_ok: assert property (p_start_ok) else $error("illegal muting start");
	property p_sync_set;
		eval && ctrl[`LCM_CTRL_RUN] && state == LCM_FIRST && sync_cnt >= sync_lim &&
			!curtain_pair_mismatch_error |=> sync_error && !muting_status;
	endproperty
	a_sync_set: assert property (p_sync_set) else $error("sync overrun missed");
	property p_sensor_end;
		eval && muting_status && !ctrl[`LCM_CTRL_FWD4] &&
			!(snap.first_entry_sensor && snap.second_entry_sensor) |=> !muting_status;
	endproperty
	a_sensor_end: assert property (p_sensor_end) else $error("muting kept");
	property p_timeout;
		eval && state == LCM_MUTING && mute_lim != 8'h00 && mute_cnt >= mute_ticks
			|=> !muting_status;
	endproperty
	a_timeout: assert property (p_timeout) else $error("muting over limit");
	property p_blocked_off;
		!muting_status && !curtain_act |=> !output_enable;
	endproperty
	a_blocked_off: assert property (p_blocked_off) else $error("blocked enable");
	property p_pair_end;
		$rose(curtain_pair_mismatch_error) |=> !muting_status ##1 !output_enable;
	endproperty
	a_pair_end: assert property (p_pair_end) else $error("mismatch kept muting");
	property p_mute_hold;
		muting_status && ctrl[`LCM_CTRL_RUN] && !curtain_pair_mismatch_error && !ovr_bad
			|=> output_enable;
	endproperty
	a_mute_hold: assert property (p_mute_hold) else $error("enable dropped muting");

endmodule

// [tb/lcm_field.sv]
// Field model: muting sensors, override switches and light curtain pair at the pins.
// Assumes the bench states the wanted levels; the model applies them after a set lag.
`timescale 1ns/10ps
module lcm_field
	import lcm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire lcm_inputs_s want,
	input wire logic [1:0] lag,
	output lcm_inputs_s pins
);
	// ======================================================================
	// Pin update
	// All lines share one lag, so slow sensors never reorder the edges the bench asked for.
	// Each sensor line is high while it sees the workpiece and low otherwise.
	logic [1:0] cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins <= '0;
			cnt <= 2'h0;
		end else if (pins == want) begin
			cnt <= 2'h0;
		end else if (cnt >= lag) begin
			pins <= want;
			cnt <= 2'h0;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end
endmodule

// [tb/lcm_bench.sv]
// Self-checking bench for the light curtain muting supervisor.
// Assumes the field model drives the pins and an APB master on pclk configures the block.
`timescale 1ns/10ps
`include "lcm_map.svh"
module light_curtain_muting_supervisor_bench
	import lcm_pkg::*;
;
	// ======================================================================
	// Signals
	// A short scan keeps the long muting limit affordable in simulation.
	localparam int SCAN = 4;
	localparam int ST = 4;
	localparam int LIMIT = 9000;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	lcm_inputs_s want = 8'hc0;
	lcm_inputs_s pins;
	logic [1:0] lag = 2'h0;
	wire [6:0] fl;
	logic [31:0] rd;
	logic er;
	logic [31:0] rstv [4];
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	int gap;

	initial begin
		forever #4 pclk = ~pclk;
	end

	lcm_field FIELD (.pclk(pclk), .presetn(presetn), .want(want), .lag(lag), .pins(pins));

	lcm_top #(.SCAN_CYCLES(SCAN)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.curtain_a(pins.curtain_a), .curtain_b(pins.curtain_b),
		.override_a(pins.override_a), .override_b(pins.override_b),
		.first_entry_sensor(pins.first_entry_sensor),
		.second_entry_sensor(pins.second_entry_sensor),
		.first_exit_sensor(pins.first_exit_sensor),
		.second_exit_sensor(pins.second_exit_sensor),
		.output_enable(fl[6]), .muting_status(fl[5]), .fault_present(fl[4]),
		.curtain_pair_mismatch_error(fl[3]), .override_mismatch_error(fl[2]),
		.sync_error(fl[1]), .sequence_error(fl[0])
	);

	// ======================================================================
	// Tasks
	task conclude;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Flags are {enable, muting, fault, curtain, override, sync, sequence}; m hides open bits.
	task flags(input string what, input logic [6:0] e, input logic [6:0] m);
		check(what, {25'h0, fl & m}, {25'h0, e & m});
	endtask

	task ticks(input int n);
		repeat (n * SCAN) @(posedge pclk);
	endtask

	task field(input logic [7:0] v, input int n);
		@(posedge pclk);
		want <= v;
		ticks(n);
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task mute_in;
		field(8'hc8, gap);
		field(8'hcc, ST);
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			failures++;
			conclude();
		end
	end

	// ======================================================================
	// Main sequence
	initial begin
		void'($urandom(64));
		lag = 2'($urandom % 3);
		rstv = '{32'(`LCM_CTRL_RST), 32'(`LCM_SYNC_RST), 32'(`LCM_MUTE_RST), 32'(`LCM_DISC_RST)};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			check("reset value", rd, rstv[i]);
		end
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped error", {31'h0, er}, 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, `LCM_OFS_SYNC, 32'h8);
		apb(1'b1, `LCM_OFS_DISC, 32'h2);
		apb(1'b1, `LCM_OFS_MUTE, 32'h0);
		apb(1'b0, `LCM_OFS_SYNC, 32'h0);
		check("sync window", rd, 32'h8);
		apb(1'b1, `LCM_OFS_CTRL, 32'h5);
		field(8'hc0, ST);
		flags("armed", 7'h40, 7'h7f);
		$display("test registers done");
		gap = 2 + int'($urandom % 3);
		mute_in();
		flags("muting on", 7'h60, 7'h7f);
		field(8'h0c, ST);
		flags("muted blocked", 7'h60, 7'h7f);
		field(8'h04, ST);
		flags("release blocked", 7'h00, 7'h6f);
		field(8'hc0, ST);
		mute_in();
		flags("re-entry", 7'h60, 7'h7f);
		field(8'hc8, ST);
		flags("second off", 7'h40, 7'h7f);
		field(8'hc0, ST);
		$display("test muting done");
		field(8'hc4, ST);
		flags("wrong order", 7'h41, 7'h7f);
		field(8'h04, ST);
		flags("blocked order error", 7'h11, 7'h7f);
		field(8'hc0, ST);
		mute_in();
		flags("order error held", 7'h01, 7'h03);
		field(8'hc0, ST);
		apb(1'b1, `LCM_OFS_CTRL, 32'h0);
		apb(1'b1, `LCM_OFS_CTRL, 32'h5);
		ticks(ST);
		flags("restart", 7'h40, 7'h7f);
		apb(1'b0, `LCM_OFS_STAT, 32'h0);
		check("status word", rd, 32'h0c0);
		$display("test sequence done");
		field(8'hc8, 12);
		flags("late second", 7'h42, 7'h7f);
		field(8'h08, ST);
		flags("blocked sync error", 7'h12, 7'h7f);
		field(8'hc0, ST);
		mute_in();
		flags("valid entry clears", 7'h60, 7'h6f);
		field(8'h4c, 5);
		flags("curtain mismatch", 7'h18, 7'h7f);
		field(8'hc0, ST);
		mute_in();
		flags("no start on error", 7'h08, 7'h28);
		field(8'h00, ST);
		field(8'hc0, ST);
		flags("curtain recovered", 7'h40, 7'h6f);
		$display("test curtain done");
		mute_in();
		field(8'hec, 5);
		flags("override mismatch", 7'h14, 7'h7f);
		field(8'hc0, ST);
		field(8'hf0, ST);
		field(8'hc0, ST);
		flags("override recovered", 7'h40, 7'h6f);
		field(8'h00, ST);
		field(8'h08, 2);
		field(8'h0c, ST);
		flags("blocked start", 7'h00, 7'h6f);
		field(8'hc0, ST);
		$display("test override done");
		apb(1'b1, `LCM_OFS_MUTE, 32'h1);
		field(8'hc8, 2);
		field(8'hcc, 490);
		flags("before limit", 7'h60, 7'h6f);
		ticks(15);
		flags("after limit", 7'h40, 7'h6f);
		apb(1'b1, `LCM_OFS_MUTE, 32'h0);
		field(8'hc0, ST);
		$display("test limit done");
		apb(1'b1, `LCM_OFS_CTRL, 32'h7);
		field(8'hc0, ST);
		mute_in();
		field(8'hce, ST);
		flags("exit seen", 7'h60, 7'h6f);
		field(8'hcc, ST);
		flags("exit released", 7'h40, 7'h6f);
		field(8'hc0, ST);
		field(8'hc1, ST);
		flags("exit first", 7'h41, 7'h7f);
		field(8'hc9, 2);
		field(8'hcd, ST);
		flags("not armed", 7'h41, 7'h7f);
		$display("test forward done");
		apb(1'b1, `LCM_OFS_CTRL, 32'h1);
		field(8'hc0, ST);
		mute_in();
		field(8'hec, 5);
		flags("single override", 7'h75, 7'h7f);
		field(8'hcc, ST);
		field(8'hfc, ST);
		flags("override cleared", 7'h61, 7'h7f);
		$display("test single override done");
		conclude();
	end
endmodule
